/* src/sram_cycle_decode.sv */
// Function
// R01: chips selected, load, read: start read burst
// R02: advance during read: next address, data out
// R03: read started with output enable off: tristate
// R04: read continue, output enable off: tristate
// R05: chips selected, load, write: start write burst
// R06: advance during write: next address, take lanes
// R07: write begin with no lanes: nothing stored
// R08: write continue with no lanes: advance, nothing stored
// R09: qualifier high: ignore edge, hold everything
// R10: qualifier high only stretches previous cycle
// R11: write cycles keep data and parity tristate
// R12: output enable is combinational, masked during writes
// R13: power up deselected with pins tristate
// R14: each lane writes its byte plus parity
// R15: write strobe low, no lanes: empty write
// R16: load with any select off deselects
// R17: two bit burst, linear or interleaved wrap
// R18: sleep tristates, ignores inputs, two cycle transitions
// R19: write data taken one edge after address
`timescale 1ns/100ps
`default_nettype none

module sram_cycle_decode
    import sram_cycle_pkg::*;
#(
    parameter int WBUF_WORDS = WBUF_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // address and control pins
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic chip_sel_a_n,
    input wire logic chip_sel_b,
    input wire logic chip_sel_c_n,
    input wire logic advance_or_load,
    input wire logic write_en_n,
    input wire logic [LANES-1:0] byte_lane_sel_n,
    input wire logic out_en_n,
    input wire logic clk_qualify_n,
    input wire logic sleep_req,
    input wire logic burst_interleave,
    // shared data and parity pins
    input wire logic [DATA_W-1:0] dq_in,
    output logic [DATA_W-1:0] dq_out,
    output logic dq_oe,
    input wire logic [LANES-1:0] io_parity_in,
    output logic [LANES-1:0] io_parity_out,
    output logic io_parity_oe,
    // array read port, one cycle synchronous read
    output logic array_rd_en,
    output logic [ADDR_W-1:0] array_rd_addr,
    input wire lane_word_t array_rd_data,
    // array write port, fed from the write buffer
    output logic array_wr_valid,
    input wire logic array_wr_ready,
    output wr_entry_t array_wr,
    // status
    output logic write_buffer_ready,
    output logic sleeping
);

    op_state_t state;
    op_state_t next_state;
    logic [SLEEP_CNT_W-1:0] sleep_cnt;
    logic [SLEEP_CNT_W-1:0] next_sleep_cnt;
    logic [ADDR_W-1:0] base_addr;
    logic [BURST_W-1:0] burst_cnt;
    logic [LANES-1:0] lane_en;

    // decode of the pins at this edge
    wire cs_all = !chip_sel_a_n && chip_sel_b && !chip_sel_c_n;
    wire in_sleep_path = (state == ST_SLEEP_IN) || (state == ST_SLEEP) ||
                         (state == ST_WAKE);
    wire sleep_busy = sleep_req || in_sleep_path;
    wire awake = !sleep_busy;
    wire in_burst = (state == ST_READ) || (state == ST_WRITE);

    // a write data phase is due at the next qualified edge
    wire wr_due = (state == ST_WRITE) && (lane_en != '0);
    wire push_ready;
    // a full buffer holds the edge off like a wait state
    wire buf_stall = wr_due && !push_ready;
    wire qual = !clk_qualify_n && !buf_stall && awake; // R09 R10

    wire do_load = qual && !advance_or_load;
    wire do_adv = qual && advance_or_load && in_burst; // R02 R06
    wire load_read = cs_all && write_en_n; // R01
    wire load_write = cs_all && !write_en_n; // R05 R15
    wire load_desel = !cs_all; // R16

    // burst sequence on the low address bits
    wire [BURST_W-1:0] start_low = base_addr[BURST_W-1:0];
    wire [BURST_W-1:0] step_cnt = burst_cnt + BURST_STEP;
    wire [BURST_W-1:0] cur_low = burst_interleave ?
                                 (start_low ^ burst_cnt) :
                                 (start_low + burst_cnt); // R17
    wire [BURST_W-1:0] adv_low = burst_interleave ?
                                 (start_low ^ step_cnt) :
                                 (start_low + step_cnt); // R17
    wire [ADDR_W-1:0] cur_addr = {base_addr[ADDR_W-1:BURST_W], cur_low};
    wire [ADDR_W-1:0] adv_addr = {base_addr[ADDR_W-1:BURST_W], adv_low};

    // write data phase: word on the pins one edge after its address
    wire push = qual && wr_due; // R19 R08
    wr_entry_t push_entry;
    assign push_entry.addr = cur_addr;
    assign push_entry.lane_en = lane_en; // R14
    assign push_entry.word.data = dq_in;
    assign push_entry.word.parity = io_parity_in;

    // array read: address goes out before the edge, data after it
    assign array_rd_en = (do_load && load_read) ||
                         (do_adv && (state == ST_READ)); // R01 R02
    assign array_rd_addr = do_load ? addr_in : adv_addr;

    // output drivers follow output enable without the clock
    wire drive = (state == ST_READ) && !out_en_n; // R12 R03 R04 R11
    assign dq_oe = drive;
    assign io_parity_oe = drive;
    assign dq_out = array_rd_data.data;
    assign io_parity_out = array_rd_data.parity;

    assign sleeping = (state == ST_SLEEP);

    always_comb begin
        next_state = state;
        next_sleep_cnt = sleep_cnt;
        case (state)
            ST_SLEEP_IN: begin
                if (sleep_cnt == SLEEP_DONE) begin
                    next_state = sleep_req ? ST_SLEEP : ST_WAKE; // R18
                    next_sleep_cnt = SLEEP_LAST;
                end else begin
                    next_sleep_cnt = sleep_cnt - 1'b1;
                end
            end
            ST_SLEEP: begin
                if (!sleep_req) begin
                    next_state = ST_WAKE;
                    next_sleep_cnt = SLEEP_LAST;
                end
            end
            ST_WAKE: begin
                if (sleep_cnt == SLEEP_DONE) begin
                    next_state = ST_DESEL; // R18
                end else begin
                    next_sleep_cnt = sleep_cnt - 1'b1;
                end
            end
            default: begin
                if (sleep_req) begin
                    // a pending access is dropped on sleep entry
                    next_state = ST_SLEEP_IN; // R18
                    next_sleep_cnt = SLEEP_LAST;
                end else if (do_load) begin
                    if (load_read) begin
                        next_state = ST_READ;
                    end else if (load_write) begin
                        next_state = ST_WRITE;
                    end else begin
                        next_state = ST_DESEL; // R16
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= RESET_STATE; // R13
            sleep_cnt <= SLEEP_DONE;
        end else begin
            state <= next_state;
            sleep_cnt <= next_sleep_cnt;
        end
    end

    // address latch and burst counter
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            base_addr <= '0;
            burst_cnt <= BURST_START;
        end else if (do_load && !load_desel) begin
            base_addr <= addr_in;
            burst_cnt <= BURST_START;
        end else if (do_adv) begin
            burst_cnt <= step_cnt; // R02 R04 R06 R08
        end
    end

    // lane selects travel with the address cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lane_en <= '0;
        end else if (sleep_busy) begin
            lane_en <= '0;
        end else if ((do_load && load_write) ||
                     (do_adv && (state == ST_WRITE))) begin
            lane_en <= ~byte_lane_sel_n; // R06 R07 R14 R15
        end else if (qual) begin
            lane_en <= '0;
        end
    end

    // the array may stall the drain; a full buffer then stalls the pins
    word_fifo #(
        .WIDTH(WR_ENTRY_W),
        .DEPTH(WBUF_WORDS)
    ) u_wbuf (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(push),
        .in_ready(push_ready),
        .in_data(push_entry),
        .out_valid(array_wr_valid),
        .out_ready(array_wr_ready),
        .out_data(array_wr)
    );

    assign write_buffer_ready = push_ready;

    a_read_drives: assert property ( // R01
        @(posedge clk) disable iff (sys_rst)
        do_load && load_read && !sleep_req ##1 !out_en_n |-> dq_oe)
        else $error("read cycle with output enable low not driving");

    a_dummy_read: assert property ( // R03
        @(posedge clk) disable iff (sys_rst)
        (state == ST_READ) && out_en_n |-> !dq_oe && !io_parity_oe)
        else $error("dummy read drives the pins");

    a_write_tristate: assert property ( // R11
        @(posedge clk) disable iff (sys_rst)
        do_load && load_write && !sleep_req |=>
        (state == ST_WRITE) && !dq_oe && !io_parity_oe)
        else $error("write cycle drives the pins");

    a_stall_holds: assert property ( // R09
        @(posedge clk) disable iff (sys_rst)
        clk_qualify_n && !sleep_busy |=>
        $stable(state) && $stable(burst_cnt) && $stable(base_addr))
        else $error("stalled edge changed state or address");

    a_deselect_load: assert property ( // R16
        @(posedge clk) disable iff (sys_rst)
        do_load && !cs_all && !sleep_req |=>
        (state == ST_DESEL) && !dq_oe)
        else $error("load with a select off did not deselect");

    a_burst_step: assert property ( // R17
        @(posedge clk) disable iff (sys_rst)
        do_adv && !burst_interleave ##1 !burst_interleave |->
        cur_addr[BURST_W-1:0] ==
        BURST_W'($past(cur_addr[BURST_W-1:0]) + BURST_STEP))
        else $error("linear burst address did not step by one");

    // the edge after that belongs to whatever op follows the abort
    a_abort_no_push: assert property ( // R07
        @(posedge clk) disable iff (sys_rst)
        do_load && load_write && (byte_lane_sel_n == '1) && !sleep_req
        |=> !push)
        else $error("write abort stored data");

    a_lane_data: assert property ( // R06
        @(posedge clk) disable iff (sys_rst)
        do_adv && (state == ST_WRITE) && !sleep_req |=>
        lane_en == ~$past(byte_lane_sel_n))
        else $error("continued write lost its lane selects");

    a_sleep_entry: assert property ( // R18
        @(posedge clk) disable iff (sys_rst)
        !in_sleep_path && sleep_req |=>
        (state == ST_SLEEP_IN) ##1 (state == ST_SLEEP_IN))
        else $error("sleep entry not two cycles");

    a_sleep_tristate: assert property ( // R18
        @(posedge clk) disable iff (sys_rst)
        in_sleep_path |-> !dq_oe && !io_parity_oe && !push)
        else $error("pins driven or write taken in sleep");

    a_powerup_desel: assert property ( // R13
        @(posedge clk)
        sys_rst |=> (state == ST_DESEL) && !dq_oe)
        else $error("not deselected after reset");

    a_adv_desel: assert property ( // R16
        @(posedge clk) disable iff (sys_rst)
        qual && advance_or_load && (state == ST_DESEL) |=>
        (state == ST_DESEL) && !dq_oe)
        else $error("advance after deselect left deselect");

    a_read_continue: assert property ( // R02
        @(posedge clk) disable iff (sys_rst)
        do_adv && (state == ST_READ) |-> array_rd_en ##1 (state == ST_READ))
        else $error("continued read did not fetch or left read");

    a_write_continue: assert property ( // R06
        @(posedge clk) disable iff (sys_rst)
        do_adv && (state == ST_WRITE) |=> (state == ST_WRITE))
        else $error("continued write left write");

    a_write_masked: assert property ( // R11 R12
        @(posedge clk) disable iff (sys_rst)
        (state == ST_WRITE) |-> !dq_oe && !io_parity_oe)
        else $error("output enable not masked in write");

    a_dummy_continue: assert property ( // R04
        @(posedge clk) disable iff (sys_rst)
        do_adv && (state == ST_READ) && out_en_n ##1 out_en_n |->
        (state == ST_READ) && !dq_oe && !io_parity_oe)
        else $error("dummy read continue drives the pins");

    a_load_address: assert property ( // R01 R05
        @(posedge clk) disable iff (sys_rst)
        do_load && !load_desel |=> (base_addr == $past(addr_in)) &&
        (burst_cnt == BURST_START))
        else $error("load did not take the pin address");

    a_interleave_step: assert property ( // R17
        @(posedge clk) disable iff (sys_rst)
        do_adv && burst_interleave ##1 burst_interleave |->
        (cur_addr[BURST_W-1:0] ^ base_addr[BURST_W-1:0]) ==
        BURST_W'($past(burst_cnt) + BURST_STEP))
        else $error("interleaved burst address wrong");

    a_abort_advance: assert property ( // R08
        @(posedge clk) disable iff (sys_rst)
        do_adv && (state == ST_WRITE) && (byte_lane_sel_n == '1) |=>
        !push && (state == ST_WRITE))
        else $error("write continue with no lanes stored data");

    a_empty_write: assert property ( // R15
        @(posedge clk) disable iff (sys_rst)
        do_load && load_write && (byte_lane_sel_n == '1) |=>
        (state == ST_WRITE) && (lane_en == '0))
        else $error("empty write enabled a lane");

    a_wake_two: assert property ( // R18
        @(posedge clk) disable iff (sys_rst)
        (state == ST_SLEEP) && !sleep_req |=>
        (state == ST_WAKE) ##1 (state == ST_WAKE) ##1 (state == ST_DESEL))
        else $error("sleep exit not two cycles");

    a_first_push: assert property ( // R14 R19
        @(posedge clk) disable iff (sys_rst)
        do_load && load_write && (byte_lane_sel_n != '1) ##1 qual |->
        push && (push_entry.lane_en == ~$past(byte_lane_sel_n)) &&
        (push_entry.addr == $past(addr_in)))
        else $error("write data not taken one edge after address");

endmodule

`default_nettype wire

/* src/sram_cycle_pkg.sv */
package sram_cycle_pkg;

    // array geometry: word address width and byte lanes, each lane 8 data
    // bits plus one parity bit
    localparam int ADDR_W = 21;
    localparam int LANES = 4;
    localparam int BYTE_W = 8;
    localparam int DATA_W = LANES * BYTE_W;

    // burst counter covers the two lowest address bits
    localparam int BURST_W = 2;
    localparam logic [BURST_W-1:0] BURST_START = 2'h0;
    localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;

    // sleep entry and exit each take this many clock cycles
    localparam int SLEEP_CYCLES = 2;
    localparam int SLEEP_CNT_W = 2;
    localparam logic [SLEEP_CNT_W-1:0] SLEEP_LAST =
        SLEEP_CNT_W'(SLEEP_CYCLES - 1);
    localparam logic [SLEEP_CNT_W-1:0] SLEEP_DONE = 2'h0;

    // write buffer depth between pins and array
    localparam int WBUF_DEPTH = 32;

    // clock period in ns, for reference when converting sleep timing
    localparam int CLK_PERIOD_NS = 20;

    // state of the cycle that follows the last qualified edge
    typedef enum logic [2:0] {
        ST_DESEL    = 3'h0,
        ST_READ     = 3'h1,
        ST_WRITE    = 3'h2,
        ST_SLEEP_IN = 3'h3,
        ST_SLEEP    = 3'h4,
        ST_WAKE     = 3'h5
    } op_state_t;

    localparam op_state_t RESET_STATE = ST_DESEL;

    // one word of the shared bus or the array, parity per lane
    typedef struct packed {
        logic [LANES-1:0] parity;
        logic [DATA_W-1:0] data;
    } lane_word_t;

    // one buffered write towards the array
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0] lane_en;
        lane_word_t word;
    } wr_entry_t;

    localparam int WR_ENTRY_W = $bits(wr_entry_t);

endpackage

/* src/word_fifo.sv */
`timescale 1ns/100ps
`default_nettype none

module word_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] FULL_COUNT = (PW+1)'(DEPTH);
    localparam logic [PW-1:0] LAST_SLOT = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;

    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    wire [PW-1:0] next_wr_ptr = (wr_ptr == LAST_SLOT) ? '0 :
                                PW'(wr_ptr + 1'b1);
    wire [PW-1:0] next_rd_ptr = (rd_ptr == LAST_SLOT) ? '0 :
                                PW'(rd_ptr + 1'b1);

    assign in_ready = (count != FULL_COUNT);
    assign out_valid = (count != '0);
    // storage is flops, so the head word is already a register output
    assign out_data = mem[rd_ptr];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= next_wr_ptr;
            end
            if (pop) begin
                rd_ptr <= next_rd_ptr;
            end
            if (push && !pop) begin
                count <= (PW+1)'(count + 1'b1);
            end else if (pop && !push) begin
                count <= (PW+1)'(count - 1'b1);
            end
        end
    end

    a_count_bound: assert property (@(posedge clk) disable iff (sys_rst)
        count <= FULL_COUNT)
        else $error("fifo count above depth");

endmodule

`default_nettype wire

/* tb/sram_array_model.sv */
`timescale 1ns/100ps
`default_nettype none

module sram_array_model
    import sram_cycle_pkg::*;
(
    // clock
    input wire logic clk,
    // read port, registered when rd_en is high, held otherwise
    input wire logic rd_en,
    input wire logic [ADDR_W-1:0] rd_addr,
    output lane_word_t rd_data,
    // write port; hold_off stops the array taking any entries while it is high
    input wire logic wr_valid,
    output logic wr_ready,
    input wire wr_entry_t wr,
    input wire logic hold_off
);
    // only 64 words kept; the bench stays below that to save memory
    lane_word_t mem [0:63];

    initial begin
        for (int i = 0; i < 64; i++) mem[i] = '0;
        rd_data = '0;
    end

    assign wr_ready = !hold_off;

    always @(posedge clk) begin
        if (rd_en) rd_data <= mem[rd_addr[5:0]];
        for (int j = 0; j < LANES; j++) begin
            if (wr_valid && wr_ready && wr.lane_en[j]) begin
                mem[wr.addr[5:0]].data[j*BYTE_W +: BYTE_W] <=
                    wr.word.data[j*BYTE_W +: BYTE_W];
                mem[wr.addr[5:0]].parity[j] <= wr.word.parity[j];
            end
        end
    end
endmodule

`default_nettype wire

/* tb/tb_sram_cycle_decode.sv */
`timescale 1ns/100ps
`default_nettype none

module tb_sram_cycle_decode;
    import sram_cycle_pkg::*;
    logic clk, sys_rst, hold_off;
    logic [ADDR_W-1:0] addr_in, array_rd_addr;
    logic chip_sel_a_n, chip_sel_b, chip_sel_c_n, advance_or_load;
    logic write_en_n, out_en_n, clk_qualify_n, sleep_req, burst_interleave;
    logic [LANES-1:0] byte_lane_sel_n, io_parity_in, io_parity_out;
    logic [DATA_W-1:0] dq_in, dq_out;
    logic dq_oe, io_parity_oe, array_rd_en, array_wr_valid, array_wr_ready;
    logic write_buffer_ready, sleeping;
    lane_word_t array_rd_data;
    wr_entry_t array_wr;
    int errors = 0, n_checks = 0, seed = 30422, cycles = 0;
    lane_word_t ref_mem [0:63];
    lane_word_t wd [0:3];
    logic [LANES-1:0] wl [0:3];

    sram_cycle_decode #(.WBUF_WORDS(4)) uut (
        .clk(clk), .sys_rst(sys_rst), .addr_in(addr_in),
        .chip_sel_a_n(chip_sel_a_n), .chip_sel_b(chip_sel_b),
        .chip_sel_c_n(chip_sel_c_n), .advance_or_load(advance_or_load),
        .write_en_n(write_en_n), .byte_lane_sel_n(byte_lane_sel_n),
        .out_en_n(out_en_n), .clk_qualify_n(clk_qualify_n),
        .sleep_req(sleep_req), .burst_interleave(burst_interleave),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
        .io_parity_in(io_parity_in), .io_parity_out(io_parity_out),
        .io_parity_oe(io_parity_oe), .array_rd_en(array_rd_en),
        .array_rd_addr(array_rd_addr), .array_rd_data(array_rd_data),
        .array_wr_valid(array_wr_valid), .array_wr_ready(array_wr_ready),
        .array_wr(array_wr), .write_buffer_ready(write_buffer_ready),
        .sleeping(sleeping)
    );

    sram_array_model array (
        .clk(clk), .rd_en(array_rd_en), .rd_addr(array_rd_addr),
        .rd_data(array_rd_data), .wr_valid(array_wr_valid),
        .wr_ready(array_wr_ready), .wr(array_wr), .hold_off(hold_off)
    );

    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end

    // burst address: low two bits wrap, added or xored
    function automatic logic [ADDR_W-1:0] ba(logic [ADDR_W-1:0] a, int k,
                                             logic il);
        logic [1:0] c;
        c = 2'(k);
        return {a[ADDR_W-1:2], il ? (a[1:0] ^ c) : (a[1:0] + c)};
    endfunction

    task automatic chk_bit(input logic got, input logic exp, input string s);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t %s got %b", $time, s, got);
        end
    endtask

    task automatic chk_word(input lane_word_t got, input lane_word_t exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t data %h exp %h", $time, got, exp);
        end
    endtask

    // a deselect drops one randomly chosen select only
    task automatic drv(input logic sel, adv, we_n,
                       input logic [ADDR_W-1:0] a,
                       input logic [LANES-1:0] ln, input lane_word_t d);
        int r;
        r = sel ? 3 : {$random(seed)} % 3;
        chip_sel_a_n <= (r == 0);
        chip_sel_b <= (r != 1);
        chip_sel_c_n <= (r == 2);
        advance_or_load <= adv;
        write_en_n <= we_n;
        addr_in <= a;
        byte_lane_sel_n <= ln;
        dq_in <= d.data;
        io_parity_in <= d.parity;
    endtask

    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk);
            drv(0, 0, 1, '0, 4'hF, '0);
            #1 chk_bit(dq_oe, 0, "deselect oe");
        end
    endtask

    // the last data phase is only taken at the edge after the burst task
    task automatic drain;
        idle(1);
        for (int w = 0; w < 40 && array_wr_valid !== 1'b0; w++) idle(1);
        chk_bit(array_wr_valid, 0, "drain");
    endtask

    task automatic rd_burst(input logic [ADDR_W-1:0] a, input logic il, oe,
                            input int len, hold);
        @(posedge clk);
        drv(1, 0, 1, a, 4'hF, '0);
        burst_interleave <= il;
        out_en_n <= oe;
        for (int k = 0; k < len; k++) begin
            @(posedge clk);
            drv(k < len - 1, k < len - 1, 1, a, 4'hF, '0);
            clk_qualify_n <= (k == 0 && hold > 0);
            #1 chk_bit(dq_oe, !oe, "read oe");
            chk_word({io_parity_out, dq_out}, ref_mem[ba(a, k, il)]);
            if (k == 0 && !oe) begin
                out_en_n = 1;
                #1 chk_bit(dq_oe, 0, "async oe");
                out_en_n = 0;
                #1;
            end
            for (int h = 0; k == 0 && h < hold; h++) begin
                @(posedge clk);
                clk_qualify_n <= (h < hold - 1);
                #1 chk_word({io_parity_out, dq_out}, ref_mem[a]);
            end
        end
    endtask

    task automatic wr_burst(input logic [ADDR_W-1:0] a, input logic il,
                            input int len);
        logic [ADDR_W-1:0] p;
        @(posedge clk);
        drv(1, 0, 0, a, wl[0], '0);
        burst_interleave <= il;
        out_en_n <= 0;
        for (int k = 0; k < len; k++) begin
            @(posedge clk);
            drv(k < len - 1, k < len - 1, 0, a, wl[(k + 1) % 4], wd[k]);
            #1 chk_bit(dq_oe, 0, "write oe");
            chk_bit(io_parity_oe, 0, "write parity oe");
            p = ba(a, k, il);
            for (int i = 0; i < LANES; i++) begin
                if (!wl[k][i]) begin
                    ref_mem[p].data[i*8 +: 8] = wd[k].data[i*8 +: 8];
                    ref_mem[p].parity[i] = wd[k].parity[i];
                end
            end
        end
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ceiling well above the few hundred cycles the tests need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            $display("MISMATCH t=%0t timeout", $time);
            summarize();
        end
    end

    initial begin
        logic [ADDR_W-1:0] a;
        sys_rst = 1;
        hold_off = 0;
        sleep_req = 0;
        clk_qualify_n = 0;
        out_en_n = 0;
        burst_interleave = 0;
        for (int i = 0; i < 64; i++) ref_mem[i] = '0;
        drv(0, 0, 1, '0, 4'hF, '0);
        repeat (5) @(posedge clk);
        sys_rst <= 0;
        #1 chk_bit(dq_oe, 0, "power-up oe");
        chk_bit(write_buffer_ready, 1, "reset ready");
        $display("test reset done");
        for (int k = 0; k < 4; k++) begin
            wl[k] = 4'hF;
            wd[k] = {4'($random(seed)), 32'($random(seed))};
        end
        wr_burst(5, 1, 3);
        idle(2);
        chk_bit(array_wr_valid, 0, "abort stored");
        rd_burst(5, 1, 1, 4, 0);
        rd_burst(5, 0, 0, 2, 3);
        idle(1);
        $display("test abort and stall done");
        hold_off = 1;
        for (int k = 0; k < 4; k++) wl[k] = 4'h0;
        wr_burst(10, 0, 4);
        idle(1);
        chk_bit(write_buffer_ready, 0, "buffer full");
        chk_bit(array_wr_valid, 1, "buffer valid");
        hold_off = 0;
        drain();
        rd_burst(10, 0, 0, 4, 0);
        $display("test buffer done");
        @(posedge clk);
        sleep_req <= 1;
        drv(1, 0, 1, 20, 4'hF, '0);
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            #1 chk_bit(sleeping, k == 2, "sleep entry");
            chk_bit(dq_oe, 0, "sleep oe");
        end
        @(posedge clk);
        sleep_req <= 0;
        idle(3);
        chk_bit(sleeping, 0, "wake");
        $display("test sleep done");
        for (int t = 0; t < 24; t++) begin
            a = ADDR_W'({$random(seed)} % 64);
            for (int k = 0; k < 4; k++) begin
                wl[k] = 4'($random(seed));
                wd[k] = {4'($random(seed)), 32'($random(seed))};
            end
            wr_burst(a, t[0], 1 + {$random(seed)} % 4);
            drain();
            rd_burst(a, t[1], 0, 4, t % 3);
        end
        idle(1);
        $display("test random done");
        summarize();
    end
endmodule

`default_nettype wire
